//--- rsw_core.sv
// rtc square wave generator, event latching, masking and first-level interrupt
// Functional notes
// - square wave is taken from the trimmed sub-second counter, not the oscillator.
// - 4-bit select; 0 off, code n gives 2^(n-1) Hz up to 16384 Hz.
// - trim may bend one period per second by up to 8 ticks; else 50%.
// - square wave drives the pin only when pin is set to clock output.
// - seconds, periodic and alarm events merge into one clock interrupt.
// - seconds flag sets on every one-second counter rollover.
// - 3-bit periodic select: off, second, minute, hour, day, month; reset minute.
// - periodic event pulse lasts one 32 kHz oscillator period.
// - periodic event suppressed while time-setting status is high.
// - alarm flag sets when alarm comparison starts reporting a match (rising edge).
// - rising edges of periodic, seconds, alarm latch into status bits 7, 6, 5.
// - reading status clears the latched event bits.
// - mask bits 7..5 block events from interrupt; reset value zero.
`timescale 1ns/1ps
module rsw_core #(
  parameter int SUBSEC_W = rsw_pkg::SUBSEC_W,
  parameter int DATA_W = rsw_pkg::DATA_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // time counter side (same clock domain)
  input wire logic tick_32k,
  input wire logic [SUBSEC_W-1:0] subsec_cnt,
  input wire logic sec_rollover,
  input wire logic min_rollover,
  input wire logic hour_rollover,
  input wire logic day_rollover,
  input wire logic month_rollover,
  input wire logic time_set_busy,
  input wire logic alarm_match,
  // pin configuration
  input wire logic pin_is_clkout,
  // outputs
  output logic square_wave_pin,
  output logic square_wave_pin_oe,
  output logic periodic_event_pulse,
  output logic clock_irq
);
  typedef struct packed {
    logic [3:0] square_wave_select;
    logic [2:0] periodic_event_select;
    logic [2:0] event_mask;
    logic periodic_event_flag;
    logic seconds_event_flag;
    logic alarm_event_flag;
    logic per_lvl;
    logic sec_lvl;
    logic alm_lvl;
    logic per_pend;
    logic [DATA_W-1:0] rdata;
    logic sqw;
    logic sqw_oe;
    logic irq;
  } rsw_state_t;

  rsw_state_t st_r;
  rsw_state_t st_nxt;

  // wave taps assume a 15-bit count; status bits need the full data word
  if (SUBSEC_W != 15) begin : g_bad_subsec
    $error("rsw_core supports only a 15-bit sub-second count");
  end
  if (DATA_W < 16) begin : g_bad_data
    $error("rsw_core needs a data word of at least 16 bits");
  end

  // periodic trigger selected from rollover strobes
  function automatic logic per_hit(input logic [2:0] sel, input logic s, input logic m,
                                   input logic h, input logic d, input logic mo);
    unique case (sel)
      rsw_pkg::PER_SEC: per_hit = s;
      rsw_pkg::PER_MIN: per_hit = m;
      rsw_pkg::PER_HOUR: per_hit = h;
      rsw_pkg::PER_DAY: per_hit = d;
      rsw_pkg::PER_MONTH: per_hit = mo;
      default: per_hit = 1'b0;
    endcase
  endfunction

  // square wave from counter bit; code n selects bit 15-n
  // code 0 lands on the padded zero above the count
  function automatic logic sqw_bit(input logic [3:0] sel, input logic [SUBSEC_W-1:0] cnt);
    logic [3:0] idx;
    logic [SUBSEC_W:0] ext;
    idx = 4'hF - sel;
    ext = {1'b0, cnt};
    sqw_bit = ext[idx];
  endfunction

  logic rd_status;
  logic [2:0] ev_rise;
  logic [2:0] flags_now;
  logic per_trig;
  assign rd_status = reg_rd && (reg_addr == rsw_pkg::ADDR_EVT_STATUS);
  assign per_trig = per_hit(st_r.periodic_event_select, sec_rollover, min_rollover,
                            hour_rollover, day_rollover, month_rollover) && !time_set_busy;

  always_comb begin
    st_nxt = st_r;
    ev_rise = 3'h0;
    flags_now = 3'h0;
    // register writes
    if (reg_wr && reg_addr == rsw_pkg::ADDR_TIME_CTRL) begin
      st_nxt.square_wave_select = reg_wdata[rsw_pkg::SQW_SEL_LSB +: 4];
      st_nxt.periodic_event_select = reg_wdata[rsw_pkg::PER_SEL_LSB +: 3];
    end
    if (reg_wr && reg_addr == rsw_pkg::ADDR_EVT_MASK) begin
      st_nxt.event_mask = reg_wdata[rsw_pkg::BIT_ALM +: 3];
    end
    // periodic request held until the next oscillator tick, then one tick wide
    if (tick_32k) begin
      st_nxt.per_lvl = st_r.per_pend && !time_set_busy;
      st_nxt.per_pend = 1'b0;
    end
    // a trigger in a tick cycle waits for the following tick
    if (per_trig) begin
      st_nxt.per_pend = 1'b1;
    end
    st_nxt.sec_lvl = sec_rollover;
    st_nxt.alm_lvl = alarm_match;
    ev_rise[2] = st_nxt.per_lvl && !st_r.per_lvl;
    ev_rise[1] = sec_rollover && !st_r.sec_lvl;
    ev_rise[0] = alarm_match && !st_r.alm_lvl;
    // read clears, a coincident event wins
    flags_now = {st_r.periodic_event_flag, st_r.seconds_event_flag, st_r.alarm_event_flag};
    if (rd_status) begin
      flags_now = 3'h0;
    end
    flags_now = flags_now | ev_rise;
    st_nxt.periodic_event_flag = flags_now[2];
    st_nxt.seconds_event_flag = flags_now[1];
    st_nxt.alarm_event_flag = flags_now[0];
    st_nxt.irq = |(flags_now & ~st_nxt.event_mask);
    // read data, one cycle later
    st_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        rsw_pkg::ADDR_TIME_CTRL: begin
          st_nxt.rdata[rsw_pkg::SQW_SEL_LSB +: 4] = st_r.square_wave_select;
          st_nxt.rdata[rsw_pkg::PER_SEL_LSB +: 3] = st_r.periodic_event_select;
        end
        rsw_pkg::ADDR_EVT_STATUS: begin
          st_nxt.rdata[rsw_pkg::BIT_PER] = st_r.periodic_event_flag;
          st_nxt.rdata[rsw_pkg::BIT_SEC] = st_r.seconds_event_flag;
          st_nxt.rdata[rsw_pkg::BIT_ALM] = st_r.alarm_event_flag;
        end
        rsw_pkg::ADDR_EVT_MASK: st_nxt.rdata[rsw_pkg::BIT_ALM +: 3] = st_r.event_mask;
        default: st_nxt.rdata = '0;
      endcase
    end
    // trimmed counter feeds the wave, so trim bends one period per second
    st_nxt.sqw = pin_is_clkout && sqw_bit(st_r.square_wave_select, subsec_cnt);
    st_nxt.sqw_oe = pin_is_clkout;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.square_wave_select <= rsw_pkg::SQW_SEL_RST;
      st_r.periodic_event_select <= rsw_pkg::PER_SEL_RST;
      st_r.event_mask <= rsw_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign square_wave_pin = st_r.sqw;
  assign square_wave_pin_oe = st_r.sqw_oe;
  assign periodic_event_pulse = st_r.per_lvl;
  assign clock_irq = st_r.irq;

  // checks
  ev_sec_a: assert property (@(posedge mclk) disable iff (!rstn)
    sec_rollover && !st_r.sec_lvl |=> st_r.seconds_event_flag)
    else $error("seconds flag not set");
  ev_alm_a: assert property (@(posedge mclk) disable iff (!rstn)
    alarm_match && !st_r.alm_lvl |=> st_r.alarm_event_flag)
    else $error("alarm flag not set");
  rd_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status && !sec_rollover |=> !st_r.seconds_event_flag)
    else $error("status not cleared by read");
  irq_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
    clock_irq |-> |({st_r.periodic_event_flag, st_r.seconds_event_flag,
                     st_r.alarm_event_flag} & ~st_r.event_mask))
    else $error("irq without unmasked flag");
  irq_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.seconds_event_flag && !st_r.event_mask[1] |-> clock_irq)
    else $error("unmasked flag without irq");
  per_width_a: assert property (@(posedge mclk) disable iff (!rstn)
    periodic_event_pulse && !tick_32k |=> periodic_event_pulse)
    else $error("periodic pulse ended early");
  per_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
    time_set_busy && tick_32k |=> !periodic_event_pulse)
    else $error("periodic pulse while setting time");
  sqw_off_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.square_wave_select == 4'h0 |=> !square_wave_pin)
    else $error("square wave not low when off");
  per_dis_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.periodic_event_select >= 3'h6 && !st_r.per_pend |=> !st_r.per_pend)
    else $error("periodic event while disabled");
  oe_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
    !pin_is_clkout |=> !square_wave_pin_oe && !square_wave_pin)
    else $error("pin driven while not clock output");
  oe_on_a: assert property (@(posedge mclk) disable iff (!rstn)
    pin_is_clkout |=> square_wave_pin_oe)
    else $error("pin not driven in clock output mode");

  // register port
  rd_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero without read");
  rd_unmap_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr != rsw_pkg::ADDR_TIME_CTRL && reg_addr != rsw_pkg::ADDR_EVT_STATUS
    && reg_addr != rsw_pkg::ADDR_EVT_MASK |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  rd_status_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> reg_rdata[rsw_pkg::BIT_PER] == $past(st_r.periodic_event_flag))
    else $error("periodic status read wrong");
  rd_sec_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> reg_rdata[rsw_pkg::BIT_SEC] == $past(st_r.seconds_event_flag))
    else $error("seconds status read wrong");
  rd_alm_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> reg_rdata[rsw_pkg::BIT_ALM] == $past(st_r.alarm_event_flag))
    else $error("alarm status read wrong");
  rd_st_hi_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> reg_rdata[DATA_W-1:8] == '0)
    else $error("status upper bits not zero");
  rd_sqsel_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == rsw_pkg::ADDR_TIME_CTRL
    |=> reg_rdata[3:0] == $past(st_r.square_wave_select))
    else $error("square select read wrong");
  rd_persel_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == rsw_pkg::ADDR_TIME_CTRL
    |=> reg_rdata[6:4] == $past(st_r.periodic_event_select))
    else $error("periodic select read wrong");
  rd_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == rsw_pkg::ADDR_EVT_MASK |=> reg_rdata[7:5] == $past(st_r.event_mask))
    else $error("mask read wrong");
  wr_sqsel_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == rsw_pkg::ADDR_TIME_CTRL
    |=> st_r.square_wave_select == $past(reg_wdata[3:0]))
    else $error("square select not written");
  wr_persel_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == rsw_pkg::ADDR_TIME_CTRL
    |=> st_r.periodic_event_select == $past(reg_wdata[6:4]))
    else $error("periodic select not written");
  wr_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == rsw_pkg::ADDR_EVT_MASK |=> st_r.event_mask == $past(reg_wdata[7:5]))
    else $error("mask not written");
  ctrl_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    !(reg_wr && reg_addr == rsw_pkg::ADDR_TIME_CTRL) |=> $stable(st_r.square_wave_select))
    else $error("square select changed without write");
  mask_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    !(reg_wr && reg_addr == rsw_pkg::ADDR_EVT_MASK) |=> $stable(st_r.event_mask))
    else $error("mask changed without write");
  wr_status_a: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == rsw_pkg::ADDR_EVT_STATUS && ev_rise == 3'h0
    |=> $stable({st_r.periodic_event_flag, st_r.seconds_event_flag, st_r.alarm_event_flag}))
    else $error("status changed by write");

  // event flags
  ev_per_a: assert property (@(posedge mclk) disable iff (!rstn)
    ev_rise[2] |=> st_r.periodic_event_flag)
    else $error("periodic flag not set");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !rd_status && ev_rise == 3'h0
    |=> $stable({st_r.periodic_event_flag, st_r.seconds_event_flag, st_r.alarm_event_flag}))
    else $error("flags changed without event or read");
  sec_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.seconds_event_flag && !rd_status |=> st_r.seconds_event_flag)
    else $error("seconds flag lost without read");
  per_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.periodic_event_flag && !rd_status |=> st_r.periodic_event_flag)
    else $error("periodic flag lost without read");
  alm_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.alarm_event_flag && !rd_status |=> st_r.alarm_event_flag)
    else $error("alarm flag lost without read");
  clr_per_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status && !ev_rise[2] |=> !st_r.periodic_event_flag)
    else $error("periodic flag not cleared by read");
  clr_alm_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status && !ev_rise[0] |=> !st_r.alarm_event_flag)
    else $error("alarm flag not cleared by read");
  sec_level_a: assert property (@(posedge mclk) disable iff (!rstn)
    sec_rollover && st_r.sec_lvl && !st_r.seconds_event_flag |=> !st_r.seconds_event_flag)
    else $error("held seconds level set flag again");
  alm_level_a: assert property (@(posedge mclk) disable iff (!rstn)
    alarm_match && st_r.alm_lvl && !st_r.alarm_event_flag |=> !st_r.alarm_event_flag)
    else $error("held alarm level set flag again");
  per_src_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(st_r.periodic_event_flag) |-> $rose(periodic_event_pulse))
    else $error("periodic flag without pulse edge");
  sec_src_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(st_r.seconds_event_flag) |-> $past(sec_rollover))
    else $error("seconds flag without rollover");
  alm_src_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(st_r.alarm_event_flag) |-> $past(alarm_match))
    else $error("alarm flag without match");

  // interrupt line
  irq_per_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.periodic_event_flag && !st_r.event_mask[2] |-> clock_irq)
    else $error("unmasked periodic flag without irq");
  irq_alm_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.alarm_event_flag && !st_r.event_mask[0] |-> clock_irq)
    else $error("unmasked alarm flag without irq");
  irq_masked_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.event_mask == 3'h7 |-> !clock_irq)
    else $error("irq while all events masked");

  // periodic pulse
  per_trig_a: assert property (@(posedge mclk) disable iff (!rstn)
    per_trig |=> st_r.per_pend)
    else $error("periodic trigger lost");
  per_pend_a: assert property (@(posedge mclk) disable iff (!rstn)
    tick_32k && !per_trig |=> !st_r.per_pend)
    else $error("periodic request outlived its tick");
  per_off_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.periodic_event_select == rsw_pkg::PER_OFF && !st_r.per_pend |=> !st_r.per_pend)
    else $error("periodic request while off");
  per_min_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_r.periodic_event_select == rsw_pkg::PER_MIN && !min_rollover && !st_r.per_pend
    |=> !st_r.per_pend)
    else $error("minute select fired on other strobe");
  busy_pend_a: assert property (@(posedge mclk) disable iff (!rstn)
    time_set_busy && !st_r.per_pend |=> !st_r.per_pend)
    else $error("periodic request taken while setting time");
  per_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(periodic_event_pulse) |-> $past(tick_32k))
    else $error("periodic pulse started off tick");
  per_low_a: assert property (@(posedge mclk) disable iff (!rstn)
    !periodic_event_pulse && !tick_32k |=> !periodic_event_pulse)
    else $error("periodic pulse rose between ticks");
  per_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
    periodic_event_pulse && tick_32k && !st_r.per_pend |=> !periodic_event_pulse)
    else $error("periodic pulse longer than one tick");

  // square wave taps
  sqw_fast_a: assert property (@(posedge mclk) disable iff (!rstn)
    pin_is_clkout && st_r.square_wave_select == 4'hF |=> square_wave_pin == $past(subsec_cnt[0]))
    else $error("fastest square wave wrong");
  sqw_half_a: assert property (@(posedge mclk) disable iff (!rstn)
    pin_is_clkout && st_r.square_wave_select == 4'hE |=> square_wave_pin == $past(subsec_cnt[1]))
    else $error("second square wave step wrong");
  sqw_slow_a: assert property (@(posedge mclk) disable iff (!rstn)
    pin_is_clkout && st_r.square_wave_select == 4'h1
    |=> square_wave_pin == $past(subsec_cnt[SUBSEC_W-1]))
    else $error("one hertz square wave wrong");
  sec_cov_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(st_r.seconds_event_flag));
  per_cov_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(periodic_event_pulse));
  irq_cov_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(clock_irq));
  rdc_cov_c: cover property (@(posedge mclk) disable iff (!rstn) rd_status && clock_irq);
  alm_cov_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(st_r.alarm_event_flag));
endmodule

//--- rsw_pkg.sv
// package: register map, field layout and reset values for the rtc square wave and event block
package rsw_pkg;
  // register indices as printed; byte-less register port uses them directly
  localparam logic [7:0] ADDR_TIME_CTRL = 8'h17;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h19;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h21;
  // time control fields
  localparam int SQW_SEL_LSB = 0;
  localparam int PER_SEL_LSB = 4;
  // status and mask bit positions
  localparam int BIT_PER = 7;
  localparam int BIT_SEC = 6;
  localparam int BIT_ALM = 5;
  // reset values
  localparam logic [3:0] SQW_SEL_RST = 4'h0;
  localparam logic [2:0] PER_SEL_RST = 3'h2;
  localparam logic [2:0] MASK_RST = 3'h0;
  // periodic select codes
  localparam logic [2:0] PER_OFF = 3'h0;
  localparam logic [2:0] PER_SEC = 3'h1;
  localparam logic [2:0] PER_MIN = 3'h2;
  localparam logic [2:0] PER_HOUR = 3'h3;
  localparam logic [2:0] PER_DAY = 3'h4;
  localparam logic [2:0] PER_MONTH = 3'h5;
  // trimmed counter width: 15-bit sub-second count, bit k toggles at 2^(14-k) Hz
  localparam int SUBSEC_W = 15;
  localparam int DATA_W = 16;
endpackage

//--- rsw_time_src.sv
// time counter stand-in: 32 kHz tick enable and trimmed sub-second count
`timescale 1ns/1ps
module rsw_time_src (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // counter outputs
  output logic tick_32k,
  output logic [14:0] subsec_cnt
);
  logic [1:0] div_r;
  // tick every 4 clocks to keep the run short
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 2'h0;
      subsec_cnt <= 15'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      if (tick_32k) begin
        subsec_cnt <= subsec_cnt + 15'h0001;
      end
    end
  end
  assign tick_32k = (div_r == 2'h3);
endmodule

//--- tb_rtc_square_wave_and_interrupts.sv
// testbench for the rtc square wave and event block
`timescale 1ns/1ps
module tb_rtc_square_wave_and_interrupts;
  logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, busy = 0, clkout = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [5:0] ev = 6'h00;
  logic tick, sqw, sqw_oe, per_p, irq;
  logic [14:0] subsec;
  int n_errors = 0, check_count = 0, seen;
  always #4 mclk = ~mclk;
  rsw_time_src src (.mclk(mclk), .rstn(rstn), .tick_32k(tick), .subsec_cnt(subsec));
  rsw_core uut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_32k(tick),
    .subsec_cnt(subsec), .sec_rollover(ev[0]), .min_rollover(ev[1]), .hour_rollover(ev[2]),
    .day_rollover(ev[3]), .month_rollover(ev[4]), .time_set_busy(busy), .alarm_match(ev[5]),
    .pin_is_clkout(clkout), .square_wave_pin(sqw), .square_wave_pin_oe(sqw_oe),
    .periodic_event_pulse(per_p), .clock_irq(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  // one-cycle event pulse, then watch for the periodic pulse
  task automatic pulse(input logic [5:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 6'h00;
    seen = 0;
    repeat (12) begin
      @(posedge mclk);
      #1 if (per_p === 1'b1) seen = 1;
    end
  endtask
  task automatic t_reset();
    rd(8'h17, 16'h007F, 16'h0020);
    rd(8'h21, 16'h00E0, 16'h0000);
    rd(8'h19, 16'hFFFF, 16'h0000);
    rd(8'h33, 16'hFFFF, 16'h0000);
    $display("done reset values");
  endtask
  task automatic t_periodic();
    for (int c = 0; c < 8; c++) begin
      wr(8'h17, 16'(c << 4));
      pulse((c >= 1 && c <= 5) ? 6'(1 << (c - 1)) : 6'h1F);
      chk(16'(seen), 16'(c >= 1 && c <= 5));
      chk(16'(irq), 16'h0001);
      rd(8'h19, 16'h00E0, c == 1 ? 16'h00C0 : (c >= 2 && c <= 5) ? 16'h0080 : 16'h0040);
      chk(16'(irq), 16'h0000);
    end
    @(posedge mclk);
    busy <= 1'b1;
    wr(8'h17, 16'h0010);
    pulse(6'h01);
    chk(16'(seen), 16'h0000);
    rd(8'h19, 16'h00E0, 16'h0040);
    @(posedge mclk);
    busy <= 1'b0;
    $display("done periodic events");
  endtask
  task automatic t_alarm();
    wr(8'h21, 16'h0020);
    rd(8'h21, 16'h00E0, 16'h0020);
    @(posedge mclk);
    ev <= 6'h20;
    repeat (4) @(posedge mclk);
    #1 chk(16'(irq), 16'h0000);
    rd(8'h19, 16'h00E0, 16'h0020);
    rd(8'h19, 16'h00E0, 16'h0000);
    wr(8'h21, 16'h0000);
    ev <= 6'h00;
    pulse(6'h20);
    chk(16'(irq), 16'h0001);
    rd(8'h19, 16'h00E0, 16'h0020);
    $display("done alarm and mask");
  endtask
  task automatic t_square();
    int tg;
    logic prev;
    @(posedge mclk);
    clkout <= 1'b1;
    for (int c = 15; c >= 13; c--) begin
      wr(8'h17, 16'(c == 13 ? 0 : c));
      tg = 0;
      prev = sqw;
      repeat (64) begin
        @(posedge mclk);
        #1 if (sqw !== prev) tg++;
        prev = sqw;
      end
      chk(16'(tg >= (c - 13) * 8 - 1 && tg <= (c - 13) * 8 + 1), 16'h0001);
      chk(16'(sqw_oe), 16'h0001);
    end
    chk(16'(sqw), 16'h0000);
    wr(8'h17, 16'h000F);
    clkout <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(16'({sqw_oe, sqw}), 16'h0000);
    $display("done square wave");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_periodic();
    t_alarm();
    t_square();
    print_verdict();
  end
  // tests need about 4 us
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
